// ### rtl/bptd_top.sv
// Breakpoint, trigger, trace and register access for the debug unit
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module bptd_top #(
  parameter bit TRACE_EN = 1'b1
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [3:0]  hprot,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Core observation
  input  wire logic [31:0] cpu_addr,
  input  wire logic        cpu_addr_valid,
  input  wire logic [31:0] cpu_data,
  input  wire logic        cpu_data_valid,
  input  wire logic [31:0] cpu_pc,
  input  wire logic        cpu_pc_valid,
  input  wire logic [3:0]  cpu_status,
  input  wire logic [31:0] cpu_capture,
  input  wire logic        cpu_capture_valid,
  input  wire logic        cpu_dbg_int_done,
  input  wire logic [2:0]  cpu_irq_level,
  // Core control
  output logic             cpu_halt_req,
  output logic             cpu_dbg_int_req,
  output logic             cpu_irq_allow,
  // Trace
  output logic [3:0]       processor_status_bus,
  output logic [3:0]       debug_data_bus,
  output logic             trace_clock_out,
  output logic             all_status_and,
  // Serial debug channel
  input  wire logic        dbg_serial_clk,
  input  wire logic        dbg_serial_in,
  output logic             dbg_serial_out
);

  // Breakpoint register file
  logic [31:0] bp_q [0:bptd_pkg::NUM_BP_REGS-1];
  logic [31:0] ctrl_q;
  logic        halt_q, armed_q, trig_q, dbgint_q;

  // AHB address-phase capture
  logic        aph_wr_q;
  logic [3:0]  aph_idx_q;
  logic [31:0] hrdata_q;

  // Serial crossing
  logic        req_toggle;
  logic [36:0] req_word;
  logic        sreq_s1_q, sreq_s2_q, sreq_s3_q, sreq_seen_q;
  logic        pend_q;
  logic        cmd_wr_q;
  logic [3:0]  cmd_idx_q;
  logic [31:0] cmd_data_q;
  logic        ack_q;
  logic [31:0] resp_q;

  // Trace state
  logic [3:0]  pst_q;
  logic        allst_q;
  logic [3:0]  ddata_q;
  logic [31:0] cap_q;
  logic [3:0]  cap_cnt_q;
  logic        tclk_q;
  logic        halt_out_q, int_out_q, allow_q;

  function automatic logic [31:0] rd_mux(input logic [3:0] idx,
                                         input logic [31:0] st);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (idx < bptd_pkg::NUM_BP_REGS) begin
      v = bp_q[idx];
    end else if (idx == bptd_pkg::IDX_CTRL) begin
      v = ctrl_q;
    end else if (idx == bptd_pkg::IDX_STATUS) begin
      v = st;
    end
    return v;
  endfunction

  wire [31:0] status_w = {28'h000_0000, dbgint_q, trig_q, armed_q, halt_q};

  // Only supervisor transfers reach the registers; others read zero
  wire ahb_take  = hsel && htrans[1] && hready;
  wire ahb_super = hprot[1];
  wire ahb_map   = (haddr[31:6] == 26'h000_0000) && (haddr[1:0] == 2'b00)
                   && (haddr[5:2] <= bptd_pkg::IDX_STATUS);
  wire ahb_ok    = ahb_take && ahb_super && ahb_map;
  wire ahb_wr    = aph_wr_q;

  // Serial request event: counts when stages two and three agree
  wire srl_new   = (sreq_s2_q == sreq_s3_q) && (sreq_s3_q != sreq_seen_q);
  // Bus writes win the port; a serial access waits while a bus write is in its data phase
  wire srl_srv   = pend_q && !ahb_wr;
  wire srl_wr    = srl_srv && cmd_wr_q;

  wire        wr_en   = ahb_wr || srl_wr;
  wire [3:0]  wr_idx  = ahb_wr ? aph_idx_q : cmd_idx_q;
  wire [31:0] wr_data = ahb_wr ? hwdata : cmd_data_q;

  // Masked comparisons
  wire addr_hit = cpu_addr_valid &&
    (((cpu_addr ^ bp_q[bptd_pkg::IDX_ADDR]) &
      ~bp_q[bptd_pkg::IDX_ADDR_MSK]) == 32'h0000_0000);
  wire data_hit = cpu_data_valid &&
    (((cpu_data ^ bp_q[bptd_pkg::IDX_DATA]) &
      ~bp_q[bptd_pkg::IDX_DATA_MSK]) == 32'h0000_0000);

  logic [bptd_pkg::NUM_PC_REGS-1:0] pc_hit_v;
  genvar gi;
  generate
    for (gi = 0; gi < bptd_pkg::NUM_PC_REGS; gi++) begin : g_pc
      assign pc_hit_v[gi] =
        ((cpu_pc ^ bp_q[bptd_pkg::IDX_PC0 + gi]) &
         ~bp_q[bptd_pkg::IDX_PC_MSK]) == 32'h0000_0000;
    end
  endgenerate
  wire pc_hit = cpu_pc_valid && (|pc_hit_v);

  // Trigger combination
  wire [2:0] sel     = ctrl_q[bptd_pkg::CTRL_SEL_PC:bptd_pkg::CTRL_SEL_ADDR];
  wire [2:0] hits    = {pc_hit, data_hit, addr_hit};
  wire       two_lvl = ctrl_q[bptd_pkg::CTRL_TWO_LEVEL];
  wire       trg_en  = ctrl_q[bptd_pkg::CTRL_ENABLE] && !halt_q && !dbgint_q;
  wire       one_ok  = (&(hits | ~sel)) && (|sel);
  wire       lv1_ok  = (&(hits[1:0] | ~sel[1:0])) && (|sel[1:0]);
  wire       lv1_set = trg_en && two_lvl && !armed_q && lv1_ok;
  wire       fire    = trg_en &&
                       (two_lvl ? (armed_q && pc_hit) : one_ok);
  wire       act_int = ctrl_q[bptd_pkg::CTRL_ACT_INT];

  // Software clears halted, armed, triggered by STATUS write-one; debug interrupt clears on core done; hardware set wins
  wire st_wr     = wr_en && (wr_idx == bptd_pkg::IDX_STATUS);
  wire halt_clr  = st_wr && wr_data[bptd_pkg::STAT_HALTED];
  wire trig_clr  = st_wr && wr_data[bptd_pkg::STAT_TRIGGERED];
  wire arm_clr   = st_wr && wr_data[bptd_pkg::STAT_ARMED];
  wire halt_d    = (fire && !act_int) || (halt_q && !halt_clr);
  wire dbgint_d  = (fire && act_int) ||
                   (dbgint_q && !cpu_dbg_int_done);
  wire trig_d    = fire || (trig_q && !trig_clr);
  wire armed_d   = lv1_set || (armed_q && !fire && !arm_clr);

  wire [2:0] crit_lvl = ctrl_q[bptd_pkg::CTRL_CRIT_LSB +: bptd_pkg::CTRL_CRIT_W];
  wire allow_d = !dbgint_d || (cpu_irq_level >= crit_lvl);

  // Status forced to the halt code while stopped
  wire [3:0] pst_d  = !TRACE_EN ? 4'h0 :
                      (halt_d ? bptd_pkg::HALT_CODE : cpu_status);
  wire       alls_d = halt_d || (&cpu_status);
  wire       cap_ld = TRACE_EN && cpu_capture_valid && (cap_cnt_q == 4'h0);
  wire       cap_on = cap_cnt_q != 4'h0;

  // Register file writes
  generate
    for (gi = 0; gi < bptd_pkg::NUM_BP_REGS; gi++) begin : g_bp
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          bp_q[gi] <= bptd_pkg::BP_RST;
        end else if (ce && wr_en && (wr_idx == gi)) begin
          bp_q[gi] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= bptd_pkg::CTRL_RST;
    end else if (ce && wr_en && (wr_idx == bptd_pkg::IDX_CTRL)) begin
      ctrl_q <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      halt_q   <= 1'b0;
      dbgint_q <= 1'b0;
      trig_q   <= 1'b0;
      armed_q  <= 1'b0;
    end else if (ce) begin
      halt_q   <= halt_d;
      dbgint_q <= dbgint_d;
      trig_q   <= trig_d;
      armed_q  <= armed_d;
    end
  end

  // AHB-Lite: zero wait state, always OKAY
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aph_wr_q  <= 1'b0;
      aph_idx_q <= 4'h0;
      hrdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      aph_wr_q  <= ahb_ok && hwrite;
      aph_idx_q <= haddr[5:2];
      if (ahb_take) begin
        hrdata_q <= (ahb_ok && !hwrite) ? rd_mux(haddr[5:2], status_w)
                                        : 32'h0000_0000;
      end
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Serial link request crossing, three stages
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sreq_s1_q <= 1'b0;
      sreq_s2_q <= 1'b0;
      sreq_s3_q <= 1'b0;
    end else if (ce) begin
      sreq_s1_q <= req_toggle;
      sreq_s2_q <= sreq_s1_q;
      sreq_s3_q <= sreq_s2_q;
    end
  end

  // Word is held stable by the link for a whole frame after the toggle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sreq_seen_q <= 1'b0;
      pend_q      <= 1'b0;
      cmd_wr_q    <= 1'b0;
      cmd_idx_q   <= 4'h0;
      cmd_data_q  <= 32'h0000_0000;
      ack_q       <= 1'b0;
      resp_q      <= 32'h0000_0000;
    end else if (ce) begin
      if (srl_new) begin
        sreq_seen_q <= sreq_s3_q;
        pend_q      <= 1'b1;
        cmd_wr_q    <= req_word[36];
        cmd_idx_q   <= req_word[35:32];
        cmd_data_q  <= req_word[31:0];
      end else if (srl_srv) begin
        pend_q <= 1'b0;
        resp_q <= rd_mux(cmd_idx_q, status_w);
        ack_q  <= ~ack_q;
      end
    end
  end

  // Trace outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pst_q     <= 4'h0;
      allst_q   <= 1'b0;
      ddata_q   <= 4'h0;
      cap_q     <= 32'h0000_0000;
      cap_cnt_q <= 4'h0;
      tclk_q    <= 1'b0;
    end else if (ce) begin
      pst_q   <= pst_d;
      allst_q <= alls_d;
      tclk_q  <= TRACE_EN ? ~tclk_q : 1'b0;
      if (cap_ld) begin
        // Captures during a burst are dropped to keep the bus simple
        cap_q     <= cpu_capture;
        cap_cnt_q <= bptd_pkg::NIBBLES_PER_WORD;
        ddata_q   <= 4'h0;
      end else if (cap_on) begin
        ddata_q   <= cap_q[31:28];
        cap_q     <= {cap_q[27:0], 4'h0};
        cap_cnt_q <= cap_cnt_q - 4'h1;
      end else begin
        ddata_q <= 4'h0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      halt_out_q <= 1'b0;
      int_out_q  <= 1'b0;
      allow_q    <= 1'b1;
    end else if (ce) begin
      halt_out_q <= halt_d;
      int_out_q  <= dbgint_d;
      allow_q    <= allow_d;
    end
  end

  assign processor_status_bus = pst_q;
  assign debug_data_bus       = ddata_q;
  assign trace_clock_out      = tclk_q;
  assign all_status_and       = allst_q;
  assign cpu_halt_req         = halt_out_q;
  assign cpu_dbg_int_req      = int_out_q;
  assign cpu_irq_allow        = allow_q;

  bptd_serial_link u_link (
    .dbg_serial_clk (dbg_serial_clk),
    .rst            (rst),
    .dbg_serial_in  (dbg_serial_in),
    .dbg_serial_out (dbg_serial_out),
    .req_toggle     (req_toggle),
    .req_word       (req_word),
    .ack_toggle     (ack_q),
    .resp_data      (resp_q)
  );

endmodule

`default_nettype wire

// ### rtl/bptd_pkg.sv
// Shared constants for the breakpoint and trace debug unit
package bptd_pkg;

  // Register indices; byte address is four times the index
  localparam int unsigned REG_IDX_W    = 4;
  localparam logic [3:0]  IDX_ADDR     = 4'h0;
  localparam logic [3:0]  IDX_ADDR_MSK = 4'h1;
  localparam logic [3:0]  IDX_DATA     = 4'h2;
  localparam logic [3:0]  IDX_DATA_MSK = 4'h3;
  localparam logic [3:0]  IDX_PC0      = 4'h4;
  localparam logic [3:0]  IDX_PC_MSK   = 4'h8;
  localparam logic [3:0]  IDX_CTRL     = 4'h9;
  localparam logic [3:0]  IDX_STATUS   = 4'hA;
  localparam int unsigned NUM_BP_REGS  = 9;
  localparam int unsigned NUM_PC_REGS  = 4;

  // Trigger control fields
  localparam int unsigned CTRL_SEL_ADDR  = 0;
  localparam int unsigned CTRL_SEL_DATA  = 1;
  localparam int unsigned CTRL_SEL_PC    = 2;
  localparam int unsigned CTRL_TWO_LEVEL = 3;
  localparam int unsigned CTRL_ACT_INT   = 4;
  localparam int unsigned CTRL_ENABLE    = 5;
  localparam int unsigned CTRL_CRIT_LSB  = 8;
  localparam int unsigned CTRL_CRIT_W    = 3;

  // Status fields
  localparam int unsigned STAT_HALTED    = 0;
  localparam int unsigned STAT_ARMED     = 1;
  localparam int unsigned STAT_TRIGGERED = 2;
  localparam int unsigned STAT_DBG_INT   = 3;

  // Reset values and halt status code
  localparam logic [31:0] BP_RST   = 32'h0000_0000;
  localparam logic [31:0] MSK_RST  = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0700;
  localparam logic [3:0]  HALT_CODE = 4'hF;

  // Serial frame: write flag, register index, 32 data bits, MSB first
  localparam int unsigned FRAME_BITS = 37;
  localparam int unsigned FRAME_CNT_W = 6;
  localparam logic [5:0]  FRAME_LAST = 6'h24;
  localparam int unsigned RESP_BITS  = 32;
  // Answer starts after the fourth link edge of the next frame
  localparam logic [5:0]  ANS_FIRST  = 6'h03;

  // Operand capture is sent as eight nibbles
  localparam logic [3:0]  NIBBLES_PER_WORD = 4'h8;

endpackage

// ### rtl/bptd_serial_link.sv
// Serial debug channel engine running on the link clock
`timescale 1ns/10ps
`default_nettype none

module bptd_serial_link (
  input  wire logic        dbg_serial_clk,
  input  wire logic        rst,
  input  wire logic        dbg_serial_in,
  output logic             dbg_serial_out,
  output logic             req_toggle,
  output logic [36:0]      req_word,
  input  wire logic        ack_toggle,
  input  wire logic [31:0] resp_data
);

  logic        rst_s1_q, rst_s2_q;
  logic [5:0]  cnt_q;
  logic [36:0] shin_q;
  logic [31:0] shout_q;
  logic        ack_s1_q, ack_s2_q, ack_s3_q, ack_ok_q;
  logic        req_q;
  logic [36:0] word_q;
  logic        out_q;

  wire         frame_end = (cnt_q == bptd_pkg::FRAME_LAST);
  // Ack needs three link edges to cross, so the answer starts late
  wire         frame_go  = (cnt_q == bptd_pkg::ANS_FIRST);
  // Answer is ready once the returned toggle matches our request
  wire         resp_rdy  = (ack_s2_q == ack_s3_q) && (ack_s3_q == req_q);

  // Reset and ack cross into this domain; only stage two reads stage one
  always_ff @(posedge dbg_serial_clk) begin
    rst_s1_q <= rst;
    rst_s2_q <= rst_s1_q;
    ack_s1_q <= ack_toggle;
    ack_s2_q <= ack_s1_q;
    ack_s3_q <= ack_s2_q;
  end

  always_ff @(posedge dbg_serial_clk) begin
    if (rst_s2_q) begin
      cnt_q   <= 6'h00;
      shin_q  <= '0;
      shout_q <= 32'h0000_0000;
      req_q   <= 1'b0;
      word_q  <= '0;
      out_q   <= 1'b0;
      ack_ok_q <= 1'b0;
    end else begin
      shin_q <= {shin_q[35:0], dbg_serial_in};
      cnt_q  <= frame_end ? 6'h00 : cnt_q + 6'h01;
      if (frame_end) begin
        word_q <= {shin_q[35:0], dbg_serial_in};
        req_q  <= ~req_q;
      end
      // Stale answer reads as zero if the core has not replied yet
      if (frame_go) begin
        ack_ok_q <= resp_rdy;
        out_q    <= resp_rdy ? resp_data[31] : 1'b0;
        shout_q  <= resp_rdy ? {resp_data[30:0], 1'b0} : 32'h0000_0000;
      end else begin
        out_q   <= shout_q[31];
        shout_q <= {shout_q[30:0], 1'b0};
      end
    end
  end

  assign dbg_serial_out = out_q;
  assign req_toggle     = req_q;
  assign req_word       = word_q;

endmodule

`default_nettype wire

// ### test/bptd_top_asserts.sv
// Port-level assertions for the breakpoint and trace debug unit
`timescale 1ns/10ps
`default_nettype none

module bptd_top_asserts #(
  parameter bit TRACE_EN = 1'b1
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [3:0]  cpu_status,
  input wire logic [31:0] cpu_capture,
  input wire logic        cpu_capture_valid,
  input wire logic [2:0]  cpu_irq_level,
  input wire logic        cpu_halt_req,
  input wire logic        cpu_dbg_int_req,
  input wire logic        cpu_irq_allow,
  input wire logic [3:0]  processor_status_bus,
  input wire logic [3:0]  debug_data_bus,
  input wire logic        trace_clock_out,
  input wire logic        all_status_and
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire taken = hsel && htrans[1] && hready;

  AST_AND_OF_STATUS:
    assert property (all_status_and == &processor_status_bus)
    else $error("status AND output differs from status bus");
  AST_BUS_OKAY:
    assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_RDATA_HOLD:
    assert property (!$past(rst) && !$past(taken) |-> $stable(hrdata))
    else $error("read data changed without a transfer");
  AST_STATUS_FOLLOWS:
    assert property (TRACE_EN && !$past(rst) && $past(ce) && !cpu_halt_req
      && !$past(cpu_halt_req) |-> processor_status_bus == $past(cpu_status))
    else $error("status bus does not follow core status");
  AST_HALT_CODE:
    assert property (TRACE_EN && ce && $rose(cpu_halt_req)
      |-> ##[0:2] processor_status_bus == 4'hF)
    else $error("halt not shown as all ones");
  AST_TRACE_TOGGLE:
    assert property (TRACE_EN && $past(ce) && !$past(rst)
      |-> trace_clock_out != $past(trace_clock_out))
    else $error("trace clock missed a toggle");
  AST_FREEZE:
    assert property (!$past(ce) && !$past(rst)
      |-> $stable(trace_clock_out) && $stable(processor_status_bus))
    else $error("trace moved while clock enable low");
  AST_FIRST_NIBBLES:
    assert property (TRACE_EN && ce && cpu_capture_valid
      && debug_data_bus == 4'h0 && !cpu_halt_req
      |=> ##1 debug_data_bus == $past(cpu_capture[31:28], 2)
      ##1 debug_data_bus == $past(cpu_capture[27:24], 3))
    else $error("capture nibbles out of order");
  AST_IRQ_FREE:
    assert property (!$past(rst) && !cpu_dbg_int_req
      && !$past(cpu_dbg_int_req) |-> cpu_irq_allow)
    else $error("interrupt blocked outside debug interrupt");
  AST_IRQ_CRIT:
    assert property (!$past(rst) && $past(ce) && cpu_dbg_int_req
      && $past(cpu_dbg_int_req)
      |-> cpu_irq_allow == ($past(cpu_irq_level) == 3'h7))
    else $error("critical level gate wrong");
endmodule

// Critical level is assumed left at its reset value by the bench
bind bptd_top bptd_top_asserts #(.TRACE_EN(TRACE_EN)) u_asserts (
  .ref_clk(ref_clk), .rst(rst), .ce(ce), .hsel(hsel), .htrans(htrans),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .cpu_status(cpu_status), .cpu_capture(cpu_capture),
  .cpu_capture_valid(cpu_capture_valid), .cpu_irq_level(cpu_irq_level),
  .cpu_halt_req(cpu_halt_req), .cpu_dbg_int_req(cpu_dbg_int_req),
  .cpu_irq_allow(cpu_irq_allow),
  .processor_status_bus(processor_status_bus),
  .debug_data_bus(debug_data_bus), .trace_clock_out(trace_clock_out),
  .all_status_and(all_status_and));

`default_nettype wire

// ### test/bptd_tool_model.sv
// Serial debug tool model: clocks frames in and collects answers
`timescale 1ns/10ps
`default_nettype none

module bptd_tool_model (
  output var logic dbg_serial_clk,
  output var logic dbg_serial_in,
  input  wire logic dbg_serial_out
);
  initial begin
    dbg_serial_clk = 1'h1;
    dbg_serial_in  = 1'h1;
  end

  // Bare pulses only while the link reset copy settles
  task automatic pulses(input int n);
    repeat (n) begin
      dbg_serial_clk = 1'h0;
      #40 dbg_serial_clk = 1'h1;
      #40;
    end
  endtask

  // One 37-bit frame; returns the answer to the previous frame
  task automatic frame(input logic wr, input logic [3:0] idx,
                       input logic [31:0] dat, output logic [31:0] rsp);
    logic [36:0] cmd;
    cmd = {wr, idx, dat};
    rsp = '0;
    for (int i = 36; i >= 0; i--) begin
      dbg_serial_clk = 1'h0;
      dbg_serial_in  = cmd[i];
      #40 dbg_serial_clk = 1'h1;
      #40 if (i >= 2 && i <= 33) rsp[i - 2] = dbg_serial_out;
    end
    // Released line rests at pull-up level; clock parks high
    dbg_serial_in = 1'h1;
  endtask
endmodule

`default_nettype wire

// ### test/breakpoint_trace_debug_tb.sv
// Self-checking bench for the breakpoint and trace debug unit
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
  err_total++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end

module breakpoint_trace_debug_tb;
  typedef struct packed { logic [31:0] a; logic [31:0] w; logic [31:0] e; }
    bptd_row_t;
  logic        ref_clk, rst, ce, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, cpu_addr, cpu_data, cpu_pc, cap, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, irq_lvl;
  logic [3:0]  hprot, cpu_status, pst, ddat;
  logic        av, dv, pv, cv, done, halt, dbgi, allow;
  logic        sclk, sin, sout, tclk, allst;
  int          err_total = 0, compares = 0, cycles = 0;
  bptd_row_t   rows [0:10] = '{
    '{32'h0000_0000, 32'h1111_1111, 32'h1111_1111},
    '{32'h0000_0004, 32'h2222_2222, 32'h2222_2222},
    '{32'h0000_0008, 32'h3333_3333, 32'h3333_3333},
    '{32'h0000_000C, 32'h4444_4444, 32'h4444_4444},
    '{32'h0000_0010, 32'h5555_5555, 32'h5555_5555},
    '{32'h0000_0014, 32'h6666_6666, 32'h6666_6666},
    '{32'h0000_0018, 32'h7777_7777, 32'h7777_7777},
    '{32'h0000_001C, 32'h8888_8888, 32'h8888_8888},
    '{32'h0000_0020, 32'h9999_9999, 32'h9999_9999},
    '{32'h0000_002C, 32'hFFFF_FFFF, 32'h0000_0000},
    '{32'h0000_0006, 32'hAAAA_AAAA, 32'h0000_0000}};

  bptd_top u_dut (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cpu_addr(cpu_addr),
    .cpu_addr_valid(av), .cpu_data(cpu_data), .cpu_data_valid(dv),
    .cpu_pc(cpu_pc), .cpu_pc_valid(pv), .cpu_status(cpu_status),
    .cpu_capture(cap), .cpu_capture_valid(cv), .cpu_dbg_int_done(done),
    .cpu_irq_level(irq_lvl), .cpu_halt_req(halt), .cpu_dbg_int_req(dbgi),
    .cpu_irq_allow(allow), .processor_status_bus(pst),
    .debug_data_bus(ddat), .trace_clock_out(tclk), .all_status_and(allst),
    .dbg_serial_clk(sclk), .dbg_serial_in(sin), .dbg_serial_out(sout));
  bptd_tool_model u_tool (
    .dbg_serial_clk(sclk), .dbg_serial_in(sin), .dbg_serial_out(sout));

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard; whole run needs about 1150 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, d, input logic sup);
    @(posedge ref_clk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hprot  <= {2'h0, sup, 1'h1};
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  initial begin
    {hsel, hwrite, av, dv, pv, cv, done} = '0;
    {haddr, hwdata, cpu_addr, cpu_data, cpu_pc, cap} = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    hprot = 4'h3;
    irq_lvl = 3'h0;
    cpu_status = 4'h5;
    ce = 1'h1;
    rst = 1'h1;
    // Link reset copy needs edges of its own clock while reset is high
    fork
      u_tool.pulses(3);
      tick(16);
    join
    @(posedge ref_clk);
    rst <= 1'h0;
    u_tool.pulses(2);
    `CHK(allow, 1'h1)
    for (int i = 0; i < 11; i++) begin
      ahb(1'h0, 32'(4 * i), '0, 1'h1);
      `CHK(rd, (i == 9) ? bptd_pkg::CTRL_RST : bptd_pkg::BP_RST)
    end
    foreach (rows[i]) begin
      ahb(1'h1, rows[i].a, rows[i].w, 1'h1);
      ahb(1'h0, rows[i].a, '0, 1'h1);
      `CHK(rd, rows[i].e)
    end
    // User mode may neither write nor read
    ahb(1'h1, 32'h0000_0000, 32'hDEAD_BEEF, 1'h0);
    ahb(1'h0, 32'h0000_0000, '0, 1'h0);
    `CHK(rd, 32'h0000_0000)
    ahb(1'h0, 32'h0000_0000, '0, 1'h1);
    `CHK(rd, 32'h1111_1111)
    // Serial channel writes and reads the same registers
    u_tool.frame(1'h1, 4'h5, 32'h5A5A_0001, rd);
    tick(20);
    ahb(1'h0, 32'h0000_0014, '0, 1'h1);
    `CHK(rd, 32'h5A5A_0001)
    ahb(1'h1, 32'h0000_0018, 32'hA5A5_0002, 1'h1);
    u_tool.frame(1'h0, 4'h6, '0, rd);
    u_tool.frame(1'h0, bptd_pkg::IDX_STATUS, '0, rd);
    `CHK(rd, 32'hA5A5_0002)
    // Masked address trigger halts the core
    ahb(1'h1, 32'h0000_0000, 32'h1234_5600, 1'h1);
    ahb(1'h1, 32'h0000_0004, 32'h0000_00FF, 1'h1);
    ahb(1'h1, 32'h0000_0024, 32'h0000_0721, 1'h1);
    cpu_addr <= 32'h1234_5700;
    av <= 1'h1;
    tick(4);
    `CHK(halt, 1'h0)
    cpu_addr <= 32'h1234_56AB;
    tick(4);
    `CHK(halt, 1'h1)
    av <= 1'h0;
    tick(2);
    `CHK(pst, 4'hF)
    `CHK(allst, 1'h1)
    ahb(1'h1, 32'h0000_0028, 32'h0000_0007, 1'h1);
    tick(4);
    `CHK(halt, 1'h0)
    `CHK(allst, 1'h0)
    // Two-level: data hit arms, then PC hit raises debug interrupt
    ahb(1'h1, 32'h0000_0008, 32'hCAFE_0000, 1'h1);
    ahb(1'h1, 32'h0000_000C, 32'h0000_FFFF, 1'h1);
    ahb(1'h1, 32'h0000_0010, 32'h0000_0100, 1'h1);
    ahb(1'h1, 32'h0000_0020, 32'h0000_0000, 1'h1);
    ahb(1'h1, 32'h0000_0024, 32'h0000_073E, 1'h1);
    cpu_pc <= 32'h0000_0100;
    pv <= 1'h1;
    tick(4);
    `CHK(dbgi, 1'h0)
    pv <= 1'h0;
    cpu_data <= 32'hCAFE_1234;
    dv <= 1'h1;
    tick(1);
    dv <= 1'h0;
    pv <= 1'h1;
    tick(4);
    `CHK(dbgi, 1'h1)
    `CHK(halt, 1'h0)
    pv <= 1'h0;
    irq_lvl <= 3'h7;
    tick(3);
    `CHK(allow, 1'h1)
    irq_lvl <= 3'h6;
    tick(3);
    `CHK(allow, 1'h0)
    done <= 1'h1;
    tick(1);
    done <= 1'h0;
    tick(3);
    `CHK(dbgi, 1'h0)
    // Freeze trace, then send one capture word as nibbles
    ce <= 1'h0;
    tick(4);
    ce <= 1'h1;
    tick(3);
    `CHK(pst, 4'h5)
    cap <= 32'h89AB_CDEF;
    cv <= 1'h1;
    tick(1);
    cv <= 1'h0;
    for (int k = 0; k < 4 && ddat === 4'h0; k++) tick(1);
    for (int n = 7; n >= 0; n--) begin
      `CHK(ddat, 4'(32'h89AB_CDEF >> (4 * n)))
      tick(1);
    end
    end_of_test();
  end
endmodule

`default_nettype wire
